// file: bench/core_model.sv
// single-cycle core beside the sequencer: boundaries and pc
// assumes op codes 1 enable, 2 disable, 3 return
`timescale 1ns/100ps
`include "irq_seq_map.svh"
module core_model
	import irq_seq_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [1:0]  op,
	input  wire logic        hold_core,
	input  wire logic        asleep,
	input  wire pc_cmd_s     pc_cmd,
	output core_ctl_s        core_ctl,
	output logic [`PC_W-1:0] pc_q
);
	// ----------------
	// pipeline
	// ----------------
	assign core_ctl.boundary = !hold_core;
	assign core_ctl.set_gie = !hold_core && op == 2'd1;
	assign core_ctl.clr_gie = !hold_core && op == 2'd2;
	assign core_ctl.ret_op = !hold_core && op == 2'd3;
	assign core_ctl.sleeping = asleep;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_q <= 13'h0000;
		end else if (pc_cmd.redirect) begin
			pc_q <= pc_cmd.target;
		end else if (!hold_core) begin
			pc_q <= pc_q + 13'h0001;
		end
	end
endmodule

// file: bench/irq_seq_properties.sv
// port checker for the vectored interrupt sequencer
// assumes bind onto the sequencer, package compiled first
`timescale 1ns/100ps
`include "irq_seq_map.svh"
module irq_seq_properties
	import irq_seq_pkg::*;
#(
	parameter logic [`PC_W-1:0] BOOT_BASE = 13'h1C00
) (
	input wire logic             clk,
	input wire logic             rst_b,
	input wire core_ctl_s        core_ctl,
	input wire logic             sp_load,
	input wire logic             vector_table_select,
	input wire logic             reset_vector_relocate_fuse,
	input wire pc_cmd_s          pc_cmd,
	input wire logic             hold_core,
	input wire logic             global_enable_q,
	input wire logic [`SP_W-1:0] stack_ptr_q,
	input wire logic [`PC_W-1:0] reset_vector
);
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_accept_gate: assert property (pc_cmd.push |-> global_enable_q && core_ctl.boundary && !core_ctl.clr_gie)
		else $error("accept without enable");
	a_gie_cleared: assert property (pc_cmd.push |=> !global_enable_q)
		else $error("enable kept on entry");
	a_push_sp: assert property (pc_cmd.push && !sp_load |=> stack_ptr_q == $past(stack_ptr_q) - 16'h0002)
		else $error("push stack step");
	a_pop_sp: assert property (pc_cmd.pop && !sp_load |=> stack_ptr_q == $past(stack_ptr_q) + 16'h0002 && global_enable_q)
		else $error("return stack or enable");
	a_entry_time: assert property (pc_cmd.push |-> ##[3:8] pc_cmd.redirect)
		else $error("entry too long");
	a_entry_hold: assert property (pc_cmd.push |=> hold_core[*3])
		else $error("core not held");
	a_ret_shadow: assert property (pc_cmd.pop |=> !pc_cmd.push)
		else $error("no shadow after return");
	a_sei_defer: assert property (core_ctl.boundary && core_ctl.set_gie && !global_enable_q |=> !pc_cmd.push)
		else $error("no shadow after enable");
	a_vec_table: assert property (pc_cmd.redirect |-> (pc_cmd.target >= BOOT_BASE) == vector_table_select)
		else $error("vector table base");
	a_reset_vec: assert property (reset_vector == (reset_vector_relocate_fuse ? BOOT_BASE : 13'h0000))
		else $error("reset vector");
endmodule
bind vectored_interrupt_sequencer irq_seq_properties #(.BOOT_BASE(BOOT_BASE)) u_props (.clk(clk), .rst_b(rst_b),
	.core_ctl(core_ctl), .sp_load(sp_load), .vector_table_select(vector_table_select),
	.reset_vector_relocate_fuse(reset_vector_relocate_fuse), .pc_cmd(pc_cmd), .hold_core(hold_core),
	.global_enable_q(global_enable_q), .stack_ptr_q(stack_ptr_q), .reset_vector(reset_vector));

// file: bench/testbench.sv
// scenario testbench for the vectored interrupt sequencer
// assumes the core model on the core side
`timescale 1ns/100ps
module testbench
	import irq_seq_pkg::*;
;
	logic             clk, rst_b, vts, fuse, lk_app, lk_boot, slp, wk, hold, gie;
	logic [7:0]       ev, lvl, en, w1c, fl;
	logic [1:0]       op;
	logic [15:0]      sp;
	logic [12:0]      pc, rv, t;
	core_ctl_s        ctl;
	pc_cmd_s          cmd;
	int               failures, compares;
	vectored_interrupt_sequencer u_vectored_interrupt_sequencer (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
		.src_event(ev), .src_is_level(lvl), .src_enable(en), .flag_write_one(w1c), .core_ctl(ctl), .pc_now(pc),
		.sp_load_val(16'h0000), .sp_load(1'b0), .vector_table_select(vts), .reset_vector_relocate_fuse(fuse),
		.app_section_lock_bit(lk_app), .boot_section_lock_bit(lk_boot), .pc_cmd(cmd), .hold_core(hold),
		.wake_req(wk), .global_enable_q(gie), .stack_ptr_q(sp), .pending_flags(fl), .reset_vector(rv));
	core_model u_core_model (.clk(clk), .rst_b(rst_b), .op(op), .hold_core(hold), .asleep(slp), .pc_cmd(cmd),
		.core_ctl(ctl), .pc_q(pc));
	// ----------------
	// helpers
	// ----------------
	task automatic end_sim;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic do_op(input logic [1:0] c);
		op = c;
		tick(1);
		op = 2'd0;
	endtask
	task automatic wait_vec;
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (cmd.redirect === 1'b1) begin
				t = cmd.target;
				tick(1);
				return;
			end
		end
		failures++;
		end_sim;
	endtask
	task automatic ret;
		do_op(2'd3);
		for (int i = 0; i < 20; i++) begin
			if (hold === 1'b0) return;
			tick(1);
		end
		failures++;
		end_sim;
	endtask
	task automatic no_push(input int n);
		repeat (n) begin
			@(negedge clk);
			chk(16'(cmd.push), 16'h0000);
		end
		tick(1);
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic s_prio;
		en = 8'h03;
		ev = 8'h03;
		tick(1);
		ev = 8'h00;
		tick(1);
		chk(16'(fl), 16'h0003);
		do_op(2'd1);
		wait_vec;
		chk(16'(t), 16'h0002);
		chk(16'(fl), 16'h0002);
		chk(16'(gie), 16'h0000);
		chk(sp, 16'h04FD);
		do_op(2'd1);
		wait_vec;
		chk(16'(t), 16'h0004);
		chk(sp, 16'h04FB);
		ret;
		chk(sp, 16'h04FD);
		ret;
		chk(16'(gie), 16'h0001);
		chk(sp, 16'h04FF);
	endtask
	task automatic s_flags;
		en = 8'h00;
		ev = 8'h04;
		tick(1);
		ev = 8'h00;
		no_push(3);
		chk(16'(fl), 16'h0004);
		w1c = 8'h02;
		tick(1);
		w1c = 8'h04;
		chk(16'(fl), 16'h0004);
		tick(1);
		w1c = 8'h00;
		tick(1);
		chk(16'(fl), 16'h0000);
	endtask
	task automatic s_level;
		lvl = 8'h08;
		ev = 8'h08;
		tick(3);
		ev = 8'h00;
		en = 8'h08;
		no_push(5);
		ev = 8'h08;
		wait_vec;
		ev = 8'h00;
		chk(16'(t), 16'h0008);
		ret;
	endtask
	task automatic s_cli_boot;
		en = 8'h01;
		tick(1);
		ev = 8'h01;
		tick(1);
		ev = 8'h00;
		op = 2'd2;
		no_push(5);
		op = 2'd0;
		chk(16'(fl), 16'h0001);
		vts = 1'b1;
		lk_app = 1'b1;
		do_op(2'd1);
		no_push(5);
		lk_app = 1'b0;
		wait_vec;
		chk(16'(t), 16'h1C02);
		ret;
		vts = 1'b0;
		lk_boot = 1'b1;
		ev = 8'h01;
		tick(1);
		ev = 8'h00;
		no_push(5);
		lk_boot = 1'b0;
		wait_vec;
		chk(16'(t), 16'h0002);
		ret;
		chk(16'(rv), 16'h0000);
		fuse = 1'b1;
		tick(1);
		chk(16'(rv), 16'h1C00);
	endtask
	task automatic s_sleep;
		int n;
		n = 0;
		en = 8'h02;
		slp = 1'b1;
		ev = 8'h02;
		@(negedge clk);
		chk(16'(wk), 16'h0000);
		tick(1);
		ev = 8'h00;
		@(negedge clk);
		chk(16'(wk), 16'h0001);
		chk(16'(cmd.push), 16'h0001);
		tick(1);
		slp = 1'b0;
		chk(16'(hold), 16'h0001);
		for (int i = 0; i < 20 && n == 0; i++) begin
			@(negedge clk);
			if (cmd.redirect === 1'b1) n = i + 1;
		end
		chk(16'(n), 16'h0008);
		if (n == 0) end_sim;
		tick(1);
		ret;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_b, vts, fuse, lk_app, lk_boot, slp, ev, lvl, en, w1c, op} = '0;
		failures = 0;
		compares = 0;
		tick(20);
		rst_b = 1'b1;
		tick(2);
		s_prio;
		s_flags;
		s_level;
		s_cli_boot;
		s_sleep;
		end_sim;
	end
endmodule

// file: inc/irq_seq_map.svh
// constants for the vectored interrupt sequencer: vector layout and cycle counts
// assumes inclusion by the sequencer modules and the package-free header use
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH

`define PC_W            13
`define SP_W            16
`define APP_BASE        13'h0000
`define BOOT_BASE_DFLT  13'h1C00
`define VEC_STRIDE_DFLT 2
`define RESET_SP        16'h04FF
`define ENTRY_CYCLES    4
`define WAKE_EXTRA      4
`define RETURN_CYCLES   4
`define SRC_N_DFLT      8

`endif

// file: inc/irq_seq_pkg.sv
// types shared by the vectored interrupt sequencer modules
// assumes the map header for widths
`include "irq_seq_map.svh"
package irq_seq_pkg;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAKE,
		ST_ENTRY,
		ST_RETURN,
		ST_SHADOW
	} seq_state_e;

	// instruction-boundary signals from the core
	typedef struct packed {
		logic boundary;
		logic set_gie;
		logic clr_gie;
		logic ret_op;
		logic sleeping;
	} core_ctl_s;

	typedef struct packed {
		logic            redirect;
		logic [`PC_W-1:0] target;
		logic            push;
		logic            pop;
	} pc_cmd_s;

endpackage

// file: src/irq_flag_bank.sv
// per-source pending flags, enables and hardware/software clear
// assumes single clock, sources are one-cycle event pulses or levels
`timescale 1ns/100ps
`include "irq_seq_map.svh"
module irq_flag_bank
	import irq_seq_pkg::*;
#(
	parameter int SRC_N = `SRC_N_DFLT
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             clk_en,
	input  wire logic [SRC_N-1:0] src_event,
	input  wire logic [SRC_N-1:0] src_is_level,
	input  wire logic [SRC_N-1:0] sw_clear,
	input  wire logic [SRC_N-1:0] hw_clear,
	input  wire logic [SRC_N-1:0] src_enable,
	output logic      [SRC_N-1:0] pending_q,
	output logic      [SRC_N-1:0] request
);

	// ---------------------------------------------
	// flags
	// ---------------------------------------------
	genvar g;
	generate
		for (g = 0; g < SRC_N; g++) begin : g_src
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					pending_q[g] <= 1'b0;
				end else if (clk_en) begin
					if (src_is_level[g]) begin
						pending_q[g] <= src_event[g];
					end else if (src_event[g]) begin
						pending_q[g] <= 1'b1;
					end else if (sw_clear[g] || hw_clear[g]) begin
						pending_q[g] <= 1'b0;
					end
				end
			end
			assign request[g] = src_is_level[g] ? (src_event[g] & src_enable[g])
				: (pending_q[g] & src_enable[g]);
		end
	endgenerate

endmodule

// file: src/irq_priority_pick.sv
// fixed priority picker: lowest index wins, vector from base plus offset
// assumes index 0 is the external request zero, reset handled by caller
`timescale 1ns/100ps
`include "irq_seq_map.svh"
module irq_priority_pick
	import irq_seq_pkg::*;
#(
	parameter int SRC_N  = `SRC_N_DFLT,
	parameter int STRIDE = `VEC_STRIDE_DFLT
) (
	input  wire logic [SRC_N-1:0]  request,
	input  wire logic [`PC_W-1:0]  table_base,
	output logic                   any,
	output logic [SRC_N-1:0]       onehot,
	output logic [`PC_W-1:0]       vector
);

	// ---------------------------------------------
	// scan
	// ---------------------------------------------
	always_comb begin
		any    = 1'b0;
		onehot = '0;
		vector = table_base;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (request[i]) begin
				any       = 1'b1;
				onehot    = '0;
				onehot[i] = 1'b1;
				vector    = table_base + `PC_W'((i + 1) * STRIDE);
			end
		end
	end

endmodule

// file: src/vectored_interrupt_sequencer.sv
// interrupt acceptance, entry and return sequencing beside the core
// assumes the core reports instruction boundaries and obeys pc commands
// Contract
// - take a source only when its enable and global enable are set
// - lowest vector address wins; reset first, then external request zero
// - vector table select moves interrupt vectors to boot section start
// - reset vector relocate fuse starts execution at boot section
// - lock bits may suppress interrupts depending on program counter
// - accepting an interrupt clears global enable
// - setting global enable in a handler allows nesting
// - return from interrupt sets global enable
// - flag-type pending flag cleared by hardware on vectoring
// - writing one clears a flag, zero leaves it
// - flag set while source disabled stays pending
// - flags pending under cleared global enable serviced later by priority
// - level sources request only while condition is present
// - one main-program instruction runs after return before next interrupt
// - status register is never saved or restored by hardware
// - global disable acts at once, even against same-cycle requests
// - instruction after global enable runs before any interrupt
// - entry takes four cycles, pushing pc, then vector executes
// - requests wait for multi-cycle instructions to complete
// - wake from sleep adds four cycles to entry
// - return takes four cycles, pops pc, stack pointer plus two, sets enable
// - entry push decrements stack pointer by two
`timescale 1ns/100ps
`include "irq_seq_map.svh"
module vectored_interrupt_sequencer
	import irq_seq_pkg::*;
#(
	parameter int              SRC_N     = `SRC_N_DFLT,
	parameter int              STRIDE    = `VEC_STRIDE_DFLT,
	parameter logic [`PC_W-1:0] BOOT_BASE = `BOOT_BASE_DFLT
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             clk_en,
	input  wire logic [SRC_N-1:0] src_event,
	input  wire logic [SRC_N-1:0] src_is_level,
	input  wire logic [SRC_N-1:0] src_enable,
	input  wire logic [SRC_N-1:0] flag_write_one,
	input  wire core_ctl_s        core_ctl,
	input  wire logic [`PC_W-1:0] pc_now,
	input  wire logic [`SP_W-1:0] sp_load_val,
	input  wire logic             sp_load,
	input  wire logic             vector_table_select,
	input  wire logic             reset_vector_relocate_fuse,
	input  wire logic             app_section_lock_bit,
	input  wire logic             boot_section_lock_bit,
	output pc_cmd_s               pc_cmd,
	output logic                  hold_core,
	output logic                  wake_req,
	output logic                  global_enable_q,
	output logic [`SP_W-1:0]      stack_ptr_q,
	output logic [SRC_N-1:0]      pending_flags,
	output logic [`PC_W-1:0]      reset_vector
);

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	seq_state_e        state_q;
	logic [2:0]        cnt_q;
	logic [`PC_W-1:0]  vec_q;
	logic [SRC_N-1:0]  hw_clear;
	logic [SRC_N-1:0]  request;
	logic [SRC_N-1:0]  win_onehot;
	logic [`PC_W-1:0]  win_vector;
	logic [`PC_W-1:0]  table_base;
	logic              win_any;
	logic              shadow_q;
	logic              lock_block;
	logic              in_boot;
	logic              accept;
	logic              gie_eff;

	// ---------------------------------------------
	// source flags and priority
	// ---------------------------------------------
	irq_flag_bank #(
		.SRC_N (SRC_N)
	) u_flags (
		.clk          (clk),
		.rst_b        (rst_b),
		.clk_en       (clk_en),
		.src_event    (src_event),
		.src_is_level (src_is_level),
		.sw_clear     (flag_write_one),
		.hw_clear     (hw_clear),
		.src_enable   (src_enable),
		.pending_q    (pending_flags),
		.request      (request)
	);

	assign table_base = vector_table_select ? BOOT_BASE : `APP_BASE;

	irq_priority_pick #(
		.SRC_N  (SRC_N),
		.STRIDE (STRIDE)
	) u_pick (
		.request    (request),
		.table_base (table_base),
		.any        (win_any),
		.onehot     (win_onehot),
		.vector     (win_vector)
	);

	assign reset_vector = reset_vector_relocate_fuse ? BOOT_BASE : `APP_BASE;

	// ---------------------------------------------
	// acceptance
	// ---------------------------------------------
	assign in_boot    = (pc_now >= BOOT_BASE);
	// lock bits suppress interrupts whose vector points into the other section
	assign lock_block = (app_section_lock_bit && !in_boot && vector_table_select) ||
		(boot_section_lock_bit && in_boot && !vector_table_select);

	// global disable in this boundary cancels a same-cycle request
	assign gie_eff = global_enable_q && !core_ctl.clr_gie;

	assign accept = (state_q == ST_RUN) && !shadow_q && core_ctl.boundary &&
		gie_eff && win_any && !lock_block;

	assign wake_req = core_ctl.sleeping && win_any && global_enable_q && !lock_block;

	// hardware clears the flag of a non-level winner in the accept cycle, as the pc is pushed
	assign hw_clear = accept ? (win_onehot & ~src_is_level) : '0;

	// ---------------------------------------------
	// sequencer
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_RUN;
			cnt_q   <= 3'h0;
			vec_q   <= '0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_RUN: begin
					if (accept) begin
						vec_q <= win_vector;
						cnt_q <= 3'(`ENTRY_CYCLES - 1);
						state_q <= core_ctl.sleeping ? ST_WAKE : ST_ENTRY;
						if (core_ctl.sleeping) begin
							cnt_q <= 3'(`WAKE_EXTRA - 1);
						end
					end else if (core_ctl.boundary && core_ctl.ret_op) begin
						cnt_q   <= 3'(`RETURN_CYCLES - 1);
						state_q <= ST_RETURN;
					end
				end
				ST_WAKE: begin
					if (cnt_q == 3'h0) begin
						cnt_q   <= 3'(`ENTRY_CYCLES - 1);
						state_q <= ST_ENTRY;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				ST_ENTRY: begin
					if (cnt_q == 3'h0) begin
						state_q <= ST_RUN;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				ST_RETURN: begin
					if (cnt_q == 3'h0) begin
						state_q <= ST_SHADOW;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				ST_SHADOW: begin
					if (core_ctl.boundary && core_ctl.ret_op) begin
						cnt_q   <= 3'(`RETURN_CYCLES - 1);
						state_q <= ST_RETURN;
					end else if (core_ctl.boundary) begin
						state_q <= ST_RUN;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------
	// global enable and shadow after set
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			global_enable_q <= 1'b0;
		end else if (clk_en) begin
			if (accept) begin
				global_enable_q <= 1'b0;
			end else if (state_q == ST_RETURN && cnt_q == 3'h0) begin
				global_enable_q <= 1'b1;
			end else if (core_ctl.boundary && core_ctl.clr_gie) begin
				global_enable_q <= 1'b0;
			end else if (core_ctl.boundary && core_ctl.set_gie) begin
				global_enable_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shadow_q <= 1'b0;
		end else if (clk_en) begin
			if (core_ctl.boundary && core_ctl.set_gie && !global_enable_q) begin
				shadow_q <= 1'b1;
			end else if (core_ctl.boundary) begin
				shadow_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// stack pointer
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stack_ptr_q <= `RESET_SP;
		end else if (clk_en) begin
			if (accept) begin
				stack_ptr_q <= stack_ptr_q - `SP_W'(2);
			end else if (state_q == ST_RETURN && cnt_q == 3'h0) begin
				stack_ptr_q <= stack_ptr_q + `SP_W'(2);
			end else if (sp_load) begin
				stack_ptr_q <= sp_load_val;
			end
		end
	end

	// ---------------------------------------------
	// core commands; status register untouched
	// ---------------------------------------------
	always_comb begin
		pc_cmd          = '0;
		pc_cmd.push     = accept;
		pc_cmd.pop      = (state_q == ST_RETURN) && (cnt_q == 3'h0);
		pc_cmd.redirect = (state_q == ST_ENTRY) && (cnt_q == 3'h0);
		pc_cmd.target   = vec_q;
	end

	assign hold_core = (state_q == ST_WAKE) || (state_q == ST_ENTRY) || (state_q == ST_RETURN);

endmodule
